/* File: verilog/pisl_event_latch.sv */
// Latched event flags, enable mask and management interrupt behind AXI4-Lite.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "pisl_cfg.svh"

// What this block does
// - Reading the status register clears all flags but those set in the same cycle, and drops the pin unless one of them is enabled.
// - Interrupt pin is high while any set flag has its enable bit set.
// - A flag reads one while its event is pending, zero otherwise.
// - Bit 15 latches on a valid wake packet event.
// - Bit 14 latches on a gigabit role resolution error.
// - Bit 13 latches when a next page is received.
// - Bit 12 latches when the held next page has been sent.
// - Bit 11 latches on an auto-negotiation error.
// - Bit 10 latches when auto-negotiation completes.
// - Bit 9 latches when the management buffer overflows and is flushed.
// - Bit 8 latches when the sync reference clock is lost.
// - Bits 7 and 6 are reserved; read as zero, writes ignored.
// - Bit 5 latches on an automatic speed downshift.
// - Bit 4 latches on a pair polarity change.
// - Bit 3 latches on a crossover state change.
// - Bit 2 latches on a duplex mode change.
// - Bit 1 latches on a link speed change.
// - Bit 0 latches on a link up or down change.
module pisl_event_latch (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Event pulses from the detection logic on the same clock.
	input wire pisl_pkg::pisl_evt_s events,
	// Write address channel.
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// Write data channel.
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel.
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// Read data channel.
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Interrupt toward the management controller, active high.
	output logic mgmt_irq_pin
);
	import pisl_pkg::*;

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Decode a byte address; the two low bits are ignored.
	function automatic pisl_sel_e reg_sel(input logic [31:0] addr);
		logic [31:0] word;
		word = {addr[31:2], 2'h0};
		if (word == `PISL_MASK_ADDR) begin
			reg_sel = PISL_SEL_MASK;
		end else if (word == `PISL_STATUS_ADDR) begin
			reg_sel = PISL_SEL_STATUS;
		end else begin
			reg_sel = PISL_SEL_NONE;
		end
	endfunction : reg_sel

	// Unmapped addresses answer with a slave error, mapped ones with okay.
	function automatic logic [1:0] sel_resp(input pisl_sel_e sel);
		sel_resp = (sel == PISL_SEL_NONE) ? `PISL_RESP_SLVERR : `PISL_RESP_OKAY;
	endfunction : sel_resp

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic [15:0] interrupt_status;
	logic [15:0] event_enable_register;
	logic [15:0] next_status;
	logic [15:0] next_mask;
	logic [15:0] ev_vec;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic rd_clear;
	logic wr_fire;

	// ****************************************************************
	// Event mapping and flag update
	// ****************************************************************

	// Place each event on its flag position; reserved bits never set.
	always_comb begin
		ev_vec = 16'h0000;
		ev_vec[`PISL_WAKE_BIT] = events.wake_packet;
		ev_vec[`PISL_ROLE_ERR_BIT] = events.role_resolution_error;
		ev_vec[`PISL_NP_IN_BIT] = events.next_page_in;
		ev_vec[`PISL_NP_OUT_BIT] = events.next_page_out;
		ev_vec[`PISL_AN_ERR_BIT] = events.autoneg_error;
		ev_vec[`PISL_AN_DONE_BIT] = events.autoneg_done;
		ev_vec[`PISL_BUF_FAULT_BIT] = events.mgmt_buffer_fault;
		ev_vec[`PISL_REF_LOST_BIT] = events.sync_ref_lost;
		ev_vec[`PISL_RSVD_HI:`PISL_RSVD_LO] = 2'h0;
		ev_vec[`PISL_DOWNSHIFT_BIT] = events.speed_downshift;
		ev_vec[`PISL_POLARITY_BIT] = events.pair_polarity;
		ev_vec[`PISL_CROSSOVER_BIT] = events.crossover_change;
		ev_vec[`PISL_DUPLEX_BIT] = events.duplex_change;
		ev_vec[`PISL_SPEED_BIT] = events.speed_change;
		ev_vec[`PISL_LINK_BIT] = events.link_state_change;
	end

	// The clearing read is the read address handshake on the status word.
	assign rd_clear = arvalid && arready && (reg_sel(araddr) == PISL_SEL_STATUS);

	// Clear first, then OR in new events, so a colliding event survives the read.
	always_comb begin
		next_status = rd_clear ? `PISL_STATUS_RESET : interrupt_status;
		next_status = next_status | ev_vec;
	end

	// Flags latch whatever the mask says; the mask only gates the pin.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_status <= `PISL_STATUS_RESET;
		end else begin
			interrupt_status <= next_status;
		end
	end

	// ****************************************************************
	// Enable mask
	// ****************************************************************

	// Merge the byte lanes that the strobes allow into the mask.
	always_comb begin
		next_mask = event_enable_register;
		if (wr_fire && (reg_sel(aw_addr_q) == PISL_SEL_MASK)) begin
			if (w_strb_q[0]) begin
				next_mask[7:0] = w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				next_mask[15:8] = w_data_q[15:8];
			end
		end
		next_mask = next_mask & `PISL_MASK_RW_BITS;
	end

	// Mask register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_enable_register <= `PISL_MASK_RESET;
		end else begin
			event_enable_register <= next_mask;
		end
	end

	// Pin is built from next values so it moves in the same cycle as the flags.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mgmt_irq_pin <= 1'b0;
		end else begin
			mgmt_irq_pin <= |(next_status & next_mask);
		end
	end

	// ****************************************************************
	// AXI4-Lite write side
	// ****************************************************************

	// Address and data are each taken once; ready drops until the response is taken.
	assign wr_fire = !awready && !wready && !bvalid;

	// Write address capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_addr_q <= 32'h0000_0000;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_addr_q <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	// Write data capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are held; status writes are ignored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `PISL_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= sel_resp(reg_sel(aw_addr_q));
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// AXI4-Lite read side
	// ****************************************************************

	// Data is captured at the address handshake, before the clear lands.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `PISL_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= sel_resp(reg_sel(araddr));
			case (reg_sel(araddr))
				PISL_SEL_MASK: begin
					rdata <= {16'h0000, event_enable_register};
				end
				PISL_SEL_STATUS: begin
					rdata <= {16'h0000, interrupt_status};
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb_main @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Pin always equals the OR of enabled flags.
	property p_irq_follows;
		mgmt_irq_pin == (|(interrupt_status & event_enable_register));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("interrupt pin disagrees with enabled flags");

	// A quiet clearing read leaves all flags and the pin low.
	property p_read_clears;
		(rd_clear && (ev_vec == 16'h0000)) |=> (interrupt_status == 16'h0000) && !mgmt_irq_pin;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read did not clear the flags");

	// Events colliding with a clearing read are the only flags left.
	property p_no_loss;
		(rd_clear && (ev_vec != 16'h0000)) |=> (interrupt_status == $past(ev_vec));
	endproperty
	a_no_loss: assert property (p_no_loss)
		else $error("event lost during clearing read");

	// Without a clearing read no flag ever falls.
	property p_hold;
		!rd_clear |=> ((interrupt_status & $past(interrupt_status)) == $past(interrupt_status));
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag fell without a status read");

	// The read answer carries the flags as they stood at the handshake.
	property p_rdata;
		rd_clear |=> rvalid && (rdata == {16'h0000, $past(interrupt_status)});
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("status read returned wrong data");

	// Wake event sets bit 15 at the next edge.
	property p_wake;
		events.wake_packet |=> interrupt_status[`PISL_WAKE_BIT];
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake flag not latched");

	// Link change sets bit 0 and it is still set two cycles later without a read.
	property p_link;
		(events.link_state_change && !rd_clear) ##1 !rd_clear[*2] |->
			interrupt_status[`PISL_LINK_BIT];
	endproperty
	a_link: assert property (p_link)
		else $error("link change flag not held");

	// Reserved bits stay zero in both registers.
	property p_reserved;
		(interrupt_status[`PISL_RSVD_HI:`PISL_RSVD_LO] == 2'h0) &&
			(event_enable_register[`PISL_RSVD_HI:`PISL_RSVD_LO] == 2'h0);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits became set");

	// A stalled read answer holds still.
	property p_rstable;
		(rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_rstable: assert property (p_rstable)
		else $error("read answer changed while stalled");

	// Main scenarios.
	cover property (rd_clear && (interrupt_status != 16'h0000));
	cover property (rd_clear && (ev_vec != 16'h0000));
	cover property ($rose(mgmt_irq_pin));
	cover property (wr_fire && (reg_sel(aw_addr_q) == PISL_SEL_MASK));

endmodule : pisl_event_latch

/* File: verilog/pisl_cfg.svh */
// Offsets, field positions, reset values and response codes of the event latch.
`ifndef PISL_CFG_SVH
`define PISL_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PISL_MASK_IDX 32'h0000_0000
`define PISL_STATUS_IDX 32'h0000_0001
`define PISL_MASK_ADDR (`PISL_MASK_IDX << 2)
`define PISL_STATUS_ADDR (`PISL_STATUS_IDX << 2)

// ****************************************************************
// Flag positions
// ****************************************************************
`define PISL_WAKE_BIT 15
`define PISL_ROLE_ERR_BIT 14
`define PISL_NP_IN_BIT 13
`define PISL_NP_OUT_BIT 12
`define PISL_AN_ERR_BIT 11
`define PISL_AN_DONE_BIT 10
`define PISL_BUF_FAULT_BIT 9
`define PISL_REF_LOST_BIT 8
`define PISL_RSVD_HI 7
`define PISL_RSVD_LO 6
`define PISL_DOWNSHIFT_BIT 5
`define PISL_POLARITY_BIT 4
`define PISL_CROSSOVER_BIT 3
`define PISL_DUPLEX_BIT 2
`define PISL_SPEED_BIT 1
`define PISL_LINK_BIT 0

// ****************************************************************
// Reset values, writable bits and bus answers
// ****************************************************************
`define PISL_STATUS_RESET 16'h0000
`define PISL_MASK_RESET 16'h0000
`define PISL_MASK_RW_BITS 16'hFF3F
`define PISL_RESP_OKAY 2'h0
`define PISL_RESP_SLVERR 2'h2

`endif

/* File: verilog/pisl_pkg.sv */
// Types shared by the event latch and its bench.
package pisl_pkg;

	// One-cycle event pulses from the detection logic, flag order msb first.
	typedef struct packed {
		logic wake_packet;
		logic role_resolution_error;
		logic next_page_in;
		logic next_page_out;
		logic autoneg_error;
		logic autoneg_done;
		logic mgmt_buffer_fault;
		logic sync_ref_lost;
		logic speed_downshift;
		logic pair_polarity;
		logic crossover_change;
		logic duplex_change;
		logic speed_change;
		logic link_state_change;
	} pisl_evt_s;

	// Which register an address selects.
	typedef enum logic [1:0] {
		PISL_SEL_MASK,
		PISL_SEL_STATUS,
		PISL_SEL_NONE
	} pisl_sel_e;

endpackage : pisl_pkg

/* File: testbench/pisl_irq_listener.sv */
// Behavioural model of the management controller that listens to the interrupt pin.
`timescale 1ns/1ps

// ****************************************************************
// Interrupt listener
// ****************************************************************
module pisl_irq_listener (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Interrupt from the latch, active high.
	input wire logic mgmt_irq_pin,
	// Number of rising edges seen on the pin.
	output logic [7:0] irq_rises
);
	logic irq_last;

	// Count each new assertion once, so a stuck pin cannot inflate the tally.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_last <= 1'b0;
			irq_rises <= 8'h00;
		end else begin
			irq_last <= mgmt_irq_pin;
			if (mgmt_irq_pin && !irq_last) begin
				irq_rises <= irq_rises + 8'h01;
			end
		end
	end
endmodule : pisl_irq_listener

/* File: testbench/tb_phy_interrupt_status_latch.sv */
// Self-checking bench for the event latch, driven over its register bus.
`timescale 1ns/1ps
`include "pisl_cfg.svh"

module tb_phy_interrupt_status_latch;
	import pisl_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	pisl_evt_s events = '0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [3:0] wr_strb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, mgmt_irq_pin;
	logic [1:0] bresp, rresp;
	logic [7:0] irq_rises;
	int mismatches = 0;
	int comparisons = 0;

	// Clock at 100 MHz.
	always #5 aclk = ~aclk;

	pisl_event_latch dut_u (.aclk(aclk), .aresetn(aresetn), .events(events),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .mgmt_irq_pin(mgmt_irq_pin));

	pisl_irq_listener listener_u (.aclk(aclk), .aresetn(aresetn),
		.mgmt_irq_pin(mgmt_irq_pin), .irq_rises(irq_rises));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Write one word; address and data are released each at its own handshake.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw_ok;
		bit w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= wr_strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
		#1;
	endtask : wr

	// Read one word; ev is pulsed in the cycle that the address is taken.
	task automatic rd(input logic [31:0] a, input pisl_evt_s ev, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		events <= ev;
		do begin
			@(posedge aclk);
			events <= '0;
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		rready <= 1'b0;
		#1;
	endtask : rd

	// One-cycle event pulse, then a look just after the edge that took it.
	task automatic pulse(input pisl_evt_s ev);
		@(posedge aclk);
		events <= ev;
		@(posedge aclk);
		events <= '0;
		#1;
	endtask : pulse

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PISL_STATUS_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		rd(`PISL_MASK_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		wr(`PISL_MASK_ADDR, 32'hFFFF, `PISL_RESP_OKAY);
		rd(`PISL_MASK_ADDR, '0, 32'hFF3F, `PISL_RESP_OKAY);
		// Every source in turn raises the pin and lands on its own bit.
		for (int i = 0; i < 14; i++) begin
			pulse(pisl_evt_s'(14'h1 << i));
			chk("irq_pin", 32'h1, {31'h0, mgmt_irq_pin});
			rd(`PISL_STATUS_ADDR, '0, 32'h1 << ((i > 5) ? i + 2 : i), 2'h0);
			chk("irq_pin", 32'h0, {31'h0, mgmt_irq_pin});
		end
		rd(`PISL_STATUS_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		// A masked flag still latches and shows once its enable is set.
		wr(`PISL_MASK_ADDR, 32'h0, `PISL_RESP_OKAY);
		pulse(pisl_evt_s'(14'h2000));
		chk("irq_pin", 32'h0, {31'h0, mgmt_irq_pin});
		wr(`PISL_MASK_ADDR, 32'h8000, `PISL_RESP_OKAY);
		chk("irq_pin", 32'h1, {31'h0, mgmt_irq_pin});
		rd(`PISL_STATUS_ADDR, '0, 32'h8000, `PISL_RESP_OKAY);
		chk("irq_pin", 32'h0, {31'h0, mgmt_irq_pin});
		// An event in the clearing cycle survives the clear.
		rd(`PISL_STATUS_ADDR, pisl_evt_s'(14'h1), 32'h0, `PISL_RESP_OKAY);
		rd(`PISL_STATUS_ADDR, '0, 32'h1, `PISL_RESP_OKAY);
		// Status is read-only, and an unmapped word answers with an error.
		wr(`PISL_STATUS_ADDR, 32'hFFFF, `PISL_RESP_OKAY);
		rd(`PISL_STATUS_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		wr(32'h8, 32'hFFFF, `PISL_RESP_SLVERR);
		rd(32'h8, '0, 32'h0, `PISL_RESP_SLVERR);
		rd(`PISL_MASK_ADDR, '0, 32'h8000, `PISL_RESP_OKAY);
		// Byte strobes gate the lanes of a mask write; no flag is set, so the pin stays low.
		wr_strb = 4'h1;
		wr(`PISL_MASK_ADDR, 32'hFFFF, `PISL_RESP_OKAY);
		rd(`PISL_MASK_ADDR, '0, 32'h803F, `PISL_RESP_OKAY);
		wr_strb = 4'h2;
		wr(`PISL_MASK_ADDR, 32'h0, `PISL_RESP_OKAY);
		rd(`PISL_MASK_ADDR, '0, 32'h003F, `PISL_RESP_OKAY);
		wr_strb = 4'hF;
		chk("irq_rises", 32'h0000_000F, {24'h0, irq_rises});
		// A reset in mid-run drops a pending flag, the mask and the pin.
		pulse(pisl_evt_s'(14'h1));
		chk("irq_pin", 32'h1, {31'h0, mgmt_irq_pin});
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PISL_STATUS_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		rd(`PISL_MASK_ADDR, '0, 32'h0, `PISL_RESP_OKAY);
		chk("irq_pin", 32'h0, {31'h0, mgmt_irq_pin});
		give_verdict();
	end

	// Watchdog, far beyond the fewer than two hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
endmodule : tb_phy_interrupt_status_latch
